// file: sac_control.sv
// control and status of an 8-bit successive-approximation converter, wishbone slave
// assumes an external analog array and comparator; pins are asynchronous to CLK
//
// How it works
// R1 - on completion set done flag, publish result, restart on selected input
// R2 - done flag cleared by result read or any control/status write
// R3 - every reset leaves the done flag at zero
// R4 - rc select one: oscillator runs and clocks a powered converter
// R5 - rc select zero: oscillator stopped, powered converter uses bus clock
// R6 - reset clears rc select
// R7 - power bit switches converter; off means no conversions
// R8 - rc select one, power zero: oscillator runs, converter stays off
// R9 - software waits for settling before trusting results
// R10 - selector: pins 0/1, reserved 2-7, high, midpoint, low 10-15
// R11 - reset clears the selector so pin 0 is chosen
// R12 - pin-level register shows pin 1 in bit 1, pin 0 in bit 0
// R13 - reset leaves the pin-level register alone; it follows the pins
// R14 - result register read-only, loaded with the done flag at conversion end
// R15 - sample switch closed 12 bus cycles at start only, then open
// R16 - control/status write aborts, clears done flag, restarts conversion
// R17 - reset clears the power bit
// R18 - control layout: done 7, rc 6, power 5, selector 3..0, bit 4 zero
// R19 - eight result bits resolved one per step, msb first, by comparator
//
// Design decision made here: the Wishbone register port.
`default_nettype none
`include "sac_regs.svh"

module sac_control (
   // clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RESET_N,
   // wishbone slave
   input  wire logic                 WB_CYC_I,
   input  wire logic                 WB_STB_I,
   input  wire logic                 WB_WE_I,
   input  wire logic [9:0]           WB_ADR_I,
   input  wire logic [3:0]           WB_SEL_I,
   input  wire logic [31:0]          WB_DAT_I,
   output logic      [31:0]          WB_DAT_O,
   output logic                      WB_ACK_O,
   output logic                      WB_ERR_O,
   // analog front end
   input  wire logic                 ANALOG_INPUT_0,
   input  wire logic                 ANALOG_INPUT_1,
   input  wire logic                 COMPARATOR_HIGH,
   input  wire logic                 RC_OSC_IN,
   output logic                      RC_OSC_ENABLE,
   output logic                      CONVERTER_ENABLE,
   output logic                      SAMPLE_SWITCH,
   output sac_pkg::sac_source_type   SOURCE_SELECT,
   output logic      [7:0]           DAC_CODE,
   // interrupt
   output logic                      IRQ
);
   import sac_pkg::*;

   // -----------------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------------
   logic          done_q;
   logic          rc_sel_q;
   logic          power_q;
   logic [3:0]    sel_q;
   logic [7:0]    result_q;
   logic [7:0]    sar_q;
   logic [2:0]    bit_q;
   logic [3:0]    sample_cnt_q;
   logic [1:0]    settle_q;
   sac_state_type state_q;
   logic [1:0]    pin_s1_q;
   logic [1:0]    pin_s2_q;
   logic [1:0]    cmp_s_q;
   logic          irq_stat_q;
   logic          irq_en_q;
   logic          step;
   logic          osc_en;

   // -----------------------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------------------
   logic          req;
   logic          wr;
   logic          rd;
   logic [7:0]    idx;
   logic          ctrl_wr;
   logic          result_rd;
   logic          finish;
   logic          mapped;

   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
   assign idx = WB_ADR_I[9:2];
   assign wr  = req & WB_WE_I & WB_SEL_I[0];
   assign rd  = req & ~WB_WE_I;
   assign mapped = (idx == `SAC_IDX_CTRL_STATUS) | (idx == `SAC_IDX_PIN_LEVEL)
                 | (idx == `SAC_IDX_RESULT) | (idx == `SAC_IDX_IRQ_STATUS)
                 | (idx == `SAC_IDX_IRQ_ENABLE) | (idx == `SAC_IDX_IRQ_CLEAR);
   assign ctrl_wr   = wr & (idx == `SAC_IDX_CTRL_STATUS);              // [R16]
   assign result_rd = rd & (idx == `SAC_IDX_RESULT);                   // [R2]
   assign finish    = (state_q == SAC_CONVERT) & step & (bit_q == 3'h0)
                    & (settle_q == `SAC_SETTLE_CYCLES) & ~ctrl_wr;

   // selector decode, used for the mux and for the source select assertion
   function automatic sac_source_type decode_sel(input logic [3:0] s);
      if (s == 4'h0)           decode_sel = SAC_SRC_PIN0;
      else if (s == 4'h1)      decode_sel = SAC_SRC_PIN1;
      else if (!s[3])          decode_sel = SAC_SRC_RESERVED;
      else if (s == 4'h8)      decode_sel = SAC_SRC_REF_HIGH;
      else if (s == 4'h9)      decode_sel = SAC_SRC_REF_MID;
      else                     decode_sel = SAC_SRC_REF_LOW;
   endfunction

   // -----------------------------------------------------------------------------
   // clock selection
   // -----------------------------------------------------------------------------
   sac_clock_select u_clk (
      .clk                (CLK),
      .reset_n            (RESET_N),
      .rc_clock_select    (rc_sel_q),
      .converter_power_on (power_q),
      .rc_osc_in          (RC_OSC_IN),
      .rc_osc_enable      (osc_en),
      .step               (step)
   );

   // bus answer: registered, one wait state, error on unmapped addresses
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         WB_ACK_O <= 1'b0;
         WB_ERR_O <= 1'b0;
      end else begin
         WB_ACK_O <= req & mapped;
         WB_ERR_O <= req & ~mapped;
      end
   end

   // read data, bits above the byte read as zero
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (rd) begin
         case (idx)
            `SAC_IDX_CTRL_STATUS: WB_DAT_O <= {24'h000000, done_q, rc_sel_q, power_q,
                                               1'b0, sel_q};            // [R18]
            `SAC_IDX_PIN_LEVEL:   WB_DAT_O <= {30'h0, pin_s2_q};        // [R12]
            `SAC_IDX_RESULT:      WB_DAT_O <= {24'h000000, result_q};
            `SAC_IDX_IRQ_STATUS:  WB_DAT_O <= {31'h0, irq_stat_q};
            `SAC_IDX_IRQ_ENABLE:  WB_DAT_O <= {31'h0, irq_en_q};
            default:              WB_DAT_O <= 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------------------------------------------------------
   // control fields
   // -----------------------------------------------------------------------------
   // every reset clears rc select, power and selector
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rc_sel_q <= 1'b0;                                             // [R6]
         power_q  <= 1'b0;                                             // [R17]
         sel_q    <= 4'h0;                                             // [R11]
      end else if (ctrl_wr) begin
         rc_sel_q <= WB_DAT_I[`SAC_BIT_RC_SEL];
         power_q  <= WB_DAT_I[`SAC_BIT_POWER];
         sel_q    <= WB_DAT_I[`SAC_SEL_MSB:0];
      end
   end

   // done flag: set at finish wins over a result-read clear
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         done_q <= 1'b0;                                               // [R3]
      end else if (ctrl_wr) begin
         done_q <= 1'b0;                                               // [R16]
      end else if (finish) begin
         done_q <= 1'b1;                                               // [R1]
      end else if (result_rd) begin
         done_q <= 1'b0;                                               // [R2]
      end
   end

   // pin levels: synchronised, no reset so reset leaves them following the pins
   always_ff @(posedge CLK) begin
      pin_s1_q <= {ANALOG_INPUT_1, ANALOG_INPUT_0};                    // [R13]
      pin_s2_q <= pin_s1_q;
   end

   // comparator synchroniser
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         cmp_s_q <= 2'b00;
      end else begin
         cmp_s_q <= {cmp_s_q[0], COMPARATOR_HIGH};
      end
   end

   // -----------------------------------------------------------------------------
   // conversion sequencer
   // -----------------------------------------------------------------------------
   // a write restarts from sampling; power off parks the sequencer
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         state_q      <= SAC_IDLE;
         sample_cnt_q <= 4'h0;
         settle_q     <= 2'h0;
         bit_q        <= `SAC_RESULT_BITS;
         sar_q        <= 8'h00;
      end else if (!power_q || ctrl_wr) begin
         state_q      <= SAC_IDLE;                                     // [R7] [R16]
         sample_cnt_q <= 4'h0;
         settle_q     <= 2'h0;
         bit_q        <= `SAC_RESULT_BITS;
         sar_q        <= 8'h00;
      end else begin
         case (state_q)
            SAC_IDLE: begin
               state_q      <= SAC_SAMPLE;
               sample_cnt_q <= 4'h0;
            end
            SAC_SAMPLE: begin
               // sampling counts bus cycles, not conversion steps
               if (sample_cnt_q == `SAC_SAMPLE_CYCLES - 4'h1) begin
                  state_q <= SAC_CONVERT;                              // [R15]
                  settle_q <= 2'h0;
                  bit_q   <= `SAC_RESULT_BITS;
                  sar_q   <= 8'h80;
               end else begin
                  sample_cnt_q <= sample_cnt_q + 4'h1;
               end
            end
            SAC_CONVERT: begin
               if (settle_q != `SAC_SETTLE_CYCLES) begin
                  // dac register and comparator synchroniser lag each new trial code
                  settle_q <= settle_q + 2'h1;
               end else if (step) begin
                  settle_q <= 2'h0;
                  // keep trial bit if input above dac, try next bit lower
                  sar_q[bit_q] <= cmp_s_q[1];                          // [R19]
                  if (bit_q == 3'h0) begin
                     state_q      <= SAC_SAMPLE;                       // [R1]
                     sample_cnt_q <= 4'h0;
                  end else begin
                     sar_q[bit_q - 3'h1] <= 1'b1;
                     bit_q <= bit_q - 3'h1;
                  end
               end
            end
            default: state_q <= SAC_IDLE;
         endcase
      end
   end

   // result loads together with the done flag; never written by the bus
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         result_q <= 8'h00;
      end else if (finish) begin
         result_q <= {sar_q[7:1], cmp_s_q[1]};                         // [R14]
      end
   end

   // analog drive outputs
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         SAMPLE_SWITCH    <= 1'b0;
         CONVERTER_ENABLE <= 1'b0;
         RC_OSC_ENABLE    <= 1'b0;
         SOURCE_SELECT    <= SAC_SRC_PIN0;
         DAC_CODE         <= 8'h00;
      end else begin
         SAMPLE_SWITCH    <= (state_q == SAC_SAMPLE) & power_q & ~ctrl_wr; // [R15]
         CONVERTER_ENABLE <= power_q;                                  // [R7]
         RC_OSC_ENABLE    <= osc_en;                                   // [R8]
         SOURCE_SELECT    <= decode_sel(sel_q);                        // [R10]
         DAC_CODE         <= sar_q;
      end
   end

   // -----------------------------------------------------------------------------
   // interrupt
   // -----------------------------------------------------------------------------
   // sticky completion event; set wins over clear
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         irq_stat_q <= 1'b0;
         irq_en_q   <= 1'b0;
      end else begin
         if (finish) begin
            irq_stat_q <= 1'b1;
         end else if (wr && idx == `SAC_IDX_IRQ_CLEAR && WB_DAT_I[0]) begin
            irq_stat_q <= 1'b0;
         end
         if (wr && idx == `SAC_IDX_IRQ_ENABLE) begin
            irq_en_q <= WB_DAT_I[0];
         end
      end
   end

   // level output from a flop, one cycle behind the status
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= irq_stat_q & irq_en_q;
      end
   end

   // -----------------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------------
   // flag, result, sequencer and clock checks; covers mark the main scenarios
   a_done_reset: assert property (@(posedge CLK) !RESET_N |=> !done_q)   // [R3]
      else $error("done flag not cleared by reset");
   a_done_set: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R1] [R14]
      finish |=> done_q && result_q == {$past(sar_q[7:1]), $past(cmp_s_q[1])})
      else $error("done flag or result missing after finish");
   a_write_clears: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R16]
      ctrl_wr |=> !done_q && state_q == SAC_IDLE)
      else $error("control write did not abort");
   a_read_clears: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R2]
      result_rd && !finish |=> !done_q)
      else $error("result read did not clear done flag");
   a_power_off_idle: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R7]
      !power_q |=> state_q == SAC_IDLE && !finish)
      else $error("conversion ran while powered off");
   a_sample_length: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R15]
      $rose(SAMPLE_SWITCH) |-> SAMPLE_SWITCH [*8] ##1 SAMPLE_SWITCH [*4] ##1 !SAMPLE_SWITCH
         or ##[1:11] !SAMPLE_SWITCH)
      else $error("sample window length wrong");
   a_sel_decode: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R10]
      ##1 SOURCE_SELECT == decode_sel($past(sel_q)))
      else $error("source select mismatch");
   a_osc_follows: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R4] [R5] [R8]
      ##2 RC_OSC_ENABLE == $past(rc_sel_q, 2))
      else $error("oscillator enable does not follow rc select");
   a_bus_step: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R5]
      !rc_sel_q && power_q && state_q == SAC_CONVERT ##1 !rc_sel_q && power_q |-> step)
      else $error("bus clock step missing");
   a_trial_settle: assert property (@(posedge CLK) disable iff (!RESET_N)   // [R19]
      state_q == SAC_CONVERT && settle_q != `SAC_SETTLE_CYCLES && !ctrl_wr |=> $stable(sar_q))
      else $error("trial code changed before comparator settled");
   c_conversion: cover property (@(posedge CLK) finish);
   c_abort: cover property (@(posedge CLK) ctrl_wr && state_q == SAC_CONVERT);
   c_rc_convert: cover property (@(posedge CLK) finish && rc_sel_q);
   c_irq: cover property (@(posedge CLK) IRQ);
   c_reserved_sel: cover property (@(posedge CLK) SOURCE_SELECT == SAC_SRC_RESERVED);
endmodule

`default_nettype wire

// file: sac_regs.svh
// register map, field positions, reset values and timing counts of the converter control
// assumes inclusion by bare name from the package and the design files
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define SAC_IDX_CTRL_STATUS 8'h15
`define SAC_IDX_PIN_LEVEL   8'h16
`define SAC_IDX_RESULT      8'h17
`define SAC_IDX_IRQ_STATUS  8'h18
`define SAC_IDX_IRQ_ENABLE  8'h19
`define SAC_IDX_IRQ_CLEAR   8'h1A

// -----------------------------------------------------------------------------
// control/status fields
// -----------------------------------------------------------------------------
`define SAC_BIT_DONE        7
`define SAC_BIT_RC_SEL      6
`define SAC_BIT_POWER       5
`define SAC_SEL_MSB         3
`define SAC_CTRL_RESET      8'h00

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define SAC_SAMPLE_CYCLES   4'hC
`define SAC_RESULT_BITS     3'h7
`define SAC_SETTLE_CYCLES   2'h3

`endif

// file: sac_pkg.sv
// types shared by the converter control files
// assumes sac_regs.svh is reachable by bare name
`default_nettype none
`include "sac_regs.svh"

package sac_pkg;
   // conversion sequencer states
   typedef enum logic [1:0] {
      SAC_IDLE   = 2'b00,
      SAC_SAMPLE = 2'b01,
      SAC_CONVERT = 2'b10
   } sac_state_type;

   // what the input multiplexer connects to the hold capacitor
   typedef enum logic [2:0] {
      SAC_SRC_PIN0     = 3'b000,
      SAC_SRC_PIN1     = 3'b001,
      SAC_SRC_RESERVED = 3'b010,
      SAC_SRC_REF_HIGH = 3'b011,
      SAC_SRC_REF_MID  = 3'b100,
      SAC_SRC_REF_LOW  = 3'b101
   } sac_source_type;
endpackage

`default_nettype wire

// file: sac_clock_select.sv
// conversion clock selection: enable to the rc oscillator and a one-cycle step strobe
// assumes the rc oscillator output is asynchronous to CLK and is sampled here
`default_nettype none

module sac_clock_select
   import sac_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // control
   input  wire logic rc_clock_select,
   input  wire logic converter_power_on,
   // oscillator pin
   input  wire logic rc_osc_in,
   // outputs
   output logic      rc_osc_enable,
   output logic      step
);
   logic sync1_q;
   logic sync2_q;
   logic last_q;

   // oscillator runs whenever selected, even with the converter off [R4] [R5] [R8]
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rc_osc_enable <= 1'b0;
      end else begin
         rc_osc_enable <= rc_clock_select;
      end
   end

   // two-flop synchroniser; only the second stage feeds the edge detector
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q  <= 1'b0;
      end else begin
         sync1_q <= rc_osc_in;
         sync2_q <= sync1_q;
         last_q  <= sync2_q;
      end
   end

   // step every bus cycle, or on each rising oscillator edge; never when powered off
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         step <= 1'b0;
      end else if (!converter_power_on) begin
         step <= 1'b0;                                        // [R7]
      end else if (rc_clock_select) begin
         step <= sync2_q & ~last_q;                           // [R4]
      end else begin
         step <= 1'b1;                                        // [R5]
      end
   end
endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the converter control block over classic wishbone
// assumes sac_pkg and sac_control are compiled first; pins and comparator driven here
`default_nettype none
`include "sac_regs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sac_pkg::*;

   logic           clk, reset_n, cyc, stb, we, ain0, ain1, cmp_high, rc_in, rc_run;
   logic [9:0]     adr;
   logic [31:0]    dat_i, dat_o;
   logic           ack, err, rc_en, conv_en, sample_sw, irq;
   sac_source_type src;
   logic [7:0]     dac;
   logic [2:0]     rc_div;
   integer         mismatches, checked, sw_run, sw_len, sw_total, t0;

   always #5 clk = ~clk;

   sac_control u_dut (
      .CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .WB_ERR_O(err), .ANALOG_INPUT_0(ain0), .ANALOG_INPUT_1(ain1),
      .COMPARATOR_HIGH(cmp_high), .RC_OSC_IN(rc_in), .RC_OSC_ENABLE(rc_en),
      .CONVERTER_ENABLE(conv_en), .SAMPLE_SWITCH(sample_sw), .SOURCE_SELECT(src),
      .DAC_CODE(dac), .IRQ(irq));

   // ------------------------------------------------------------------
   // background: rc oscillator stand-in, sample window lengths
   // ------------------------------------------------------------------
   // slow rc clock, one rising edge every 8 bus cycles, only while rc_run is set
   always @(posedge clk) begin
      rc_div <= rc_div + 3'h1;
      rc_in <= rc_run & rc_div[2];
      if (sample_sw === 1'b1) begin
         sw_run <= sw_run + 1;
         sw_total <= sw_total + 1;
      end else begin
         if (sw_run != 0) sw_len <= sw_run;
         sw_run <= 0;
      end
   end

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic give_up(input string n);
      mismatches++;
      $display("MISMATCH %s expected completion seen timeout", n);
      report_and_stop();
   endtask

   // one classic cycle; holds everything until ack or err is sampled high
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
      integer n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      dat_i <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (ack !== 1'b1 && err !== 1'b1) give_up("bus answer");
      r = dat_o[7:0];
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      bus(1'b1, i, d, r, e);
      chk("write err", 32'h0, 32'(e));
   endtask

   task automatic rdc(input string n, input logic [7:0] i, input logic [7:0] x);
      logic [7:0] r;
      logic       e;
      bus(1'b0, i, 8'h00, r, e);
      chk(n, 32'(x), 32'(r));
   endtask

   // polls the control register; reads there leave the flag alone
   task automatic wait_done();
      logic [7:0] r;
      logic       e;
      integer     k;
      r = 8'h00;
      for (k = 0; k < 80 && r[7] !== 1'b1; k++) bus(1'b0, `SAC_IDX_CTRL_STATUS, 8'h00, r, e);
      if (r[7] !== 1'b1) give_up("done flag");
   endtask

   task automatic wait_sample();
      integer k;
      for (k = 0; k < 40 && sample_sw !== 1'b1; k++) @(posedge clk);
      if (sample_sw !== 1'b1) give_up("sample start");
   endtask

   function automatic sac_source_type src_of(input logic [3:0] s);
      if (s == 4'h0) return SAC_SRC_PIN0;
      if (s == 4'h1) return SAC_SRC_PIN1;
      if (s < 4'h8) return SAC_SRC_RESERVED;
      if (s == 4'h8) return SAC_SRC_REF_HIGH;
      if (s == 4'h9) return SAC_SRC_REF_MID;
      return SAC_SRC_REF_LOW;
   endfunction

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_reset_and_pins();
      rdc("ctrl after reset", `SAC_IDX_CTRL_STATUS, 8'h00);
      chk("source after reset", 32'(SAC_SRC_PIN0), 32'(src));
      chk("power after reset", 32'h0, 32'(conv_en));
      ain1 <= 1'b1;
      ain0 <= 1'b0;
      repeat (3) @(posedge clk);
      rdc("pins 10", `SAC_IDX_PIN_LEVEL, 8'h02);
      ain1 <= 1'b0;
      ain0 <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("pins 01", `SAC_IDX_PIN_LEVEL, 8'h01);
   endtask

   // bit 4 written high every time, must read back low
   task automatic t_selector();
      integer s;
      for (s = 0; s < 16; s++) begin
         wr(`SAC_IDX_CTRL_STATUS, 8'h10 | 8'(s));
         chk("source", 32'(src_of(4'(s))), 32'(src));
         rdc("ctrl layout", `SAC_IDX_CTRL_STATUS, 8'(s));
      end
   endtask

   task automatic t_cpu_conversion();
      integer k;
      cmp_high <= 1'b1;
      wr(`SAC_IDX_CTRL_STATUS, 8'h20);
      chk("osc off", 32'h0, 32'(rc_en));
      wait_done();
      chk("sample window", 32'd12, 32'(sw_len));
      rdc("result ones", `SAC_IDX_RESULT, 8'hFF);
      rdc("done cleared by read", `SAC_IDX_CTRL_STATUS, 8'h20);
      wait_sample();
      wr(`SAC_IDX_RESULT, 8'h00);
      rdc("result read only", `SAC_IDX_RESULT, 8'hFF);
      cmp_high <= 1'b0;
      wait_done();
      wr(`SAC_IDX_CTRL_STATUS, 8'h21);
      rdc("done cleared by write", `SAC_IDX_CTRL_STATUS, 8'h21);
      // first trial code shows while the msb is still being judged
      for (k = 0; k < 40 && sample_sw !== 1'b0; k++) @(posedge clk);
      if (sample_sw !== 1'b0) give_up("sample end");
      chk("first trial code", 32'h80, 32'(dac));
      wait_done();
      rdc("result zeros", `SAC_IDX_RESULT, 8'h00);
      chk("source pin1", 32'(SAC_SRC_PIN1), 32'(src));
   endtask

   task automatic t_rc_clock();
      cmp_high <= 1'b1;
      wr(`SAC_IDX_CTRL_STATUS, 8'h40);
      t0 = sw_total;
      repeat (40) @(posedge clk); // settling before any result is trusted
      chk("osc runs", 32'h1, 32'(rc_en));
      chk("converter off", 32'h0, 32'(conv_en));
      chk("no sampling", 32'(t0), 32'(sw_total));
      wr(`SAC_IDX_CTRL_STATUS, 8'h60);
      repeat (60) @(posedge clk);
      rdc("no rc edges no done", `SAC_IDX_CTRL_STATUS, 8'h60);
      rc_run <= 1'b1;
      wait_done();
      rdc("rc result", `SAC_IDX_RESULT, 8'hFF);
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      rc_run <= 1'b0;
      @(posedge clk);
      rdc("pins survive reset", `SAC_IDX_PIN_LEVEL, 8'h01);
      rdc("ctrl after rerun reset", `SAC_IDX_CTRL_STATUS, 8'h00);
      chk("osc stopped", 32'h0, 32'(rc_en));
   endtask

   task automatic t_irq_and_errors();
      integer     k;
      logic [7:0] r;
      logic       e;
      wr(`SAC_IDX_CTRL_STATUS, 8'h20);
      wr(`SAC_IDX_IRQ_ENABLE, 8'h01);
      for (k = 0; k < 80 && irq !== 1'b1; k++) @(posedge clk);
      chk("irq raised", 32'h1, 32'(irq));
      rdc("irq status", `SAC_IDX_IRQ_STATUS, 8'h01);
      wr(`SAC_IDX_IRQ_ENABLE, 8'h00);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      wr(`SAC_IDX_CTRL_STATUS, 8'h00);
      wr(`SAC_IDX_IRQ_CLEAR, 8'h01);
      rdc("irq status cleared", `SAC_IDX_IRQ_STATUS, 8'h00);
      wr(`SAC_IDX_IRQ_ENABLE, 8'h01);
      repeat (2) @(posedge clk);
      chk("irq quiet", 32'h0, 32'(irq));
      bus(1'b0, 8'h00, 8'h00, r, e);
      chk("unmapped err", 32'h1, 32'(e));
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      {cyc, stb, we, ain0, ain1, cmp_high, rc_in, rc_run} = 8'h00;
      adr = 10'h000;
      dat_i = 32'h00000000;
      rc_div = 3'h0;
      {mismatches, checked, sw_run, sw_len, sw_total, t0} = {6{32'sd0}};
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset_and_pins();
      t_selector();
      t_cpu_conversion();
      t_rc_clock();
      t_irq_and_errors();
      report_and_stop();
   end
endmodule

`default_nettype wire
